/* File: logic/iocc_pkg.sv */
// package for the channel command interpreter: codes, fields, timing
package iocc_pkg;
  localparam int unsigned WORD_W         = 18;
  localparam int unsigned ID_W           = 6;
  localparam int unsigned CMD_W          = 6;
  localparam int unsigned PORT_W         = 4;
  // channel command codes (octal)
  localparam logic [CMD_W-1:0] CMD_IO_RESET    = 6'o70;
  localparam logic [CMD_W-1:0] CMD_DATA_AVAIL  = 6'o71;
  localparam logic [CMD_W-1:0] CMD_UNASSIGNED  = 6'o72;
  localparam logic [CMD_W-1:0] CMD_EN_DATA     = 6'o73;
  localparam logic [CMD_W-1:0] CMD_DIS_DATA    = 6'o74;
  localparam logic [CMD_W-1:0] CMD_EN_STAT     = 6'o75;
  localparam logic [CMD_W-1:0] CMD_DIS_STAT    = 6'o76;
  localparam logic [CMD_W-1:0] CMD_STAT_REQ    = 6'o77;
  // device commands
  localparam logic [2:0] DEV_NONE        = 3'h0;
  localparam logic [2:0] DEV_LOAD_FIRST  = 3'h1;
  localparam logic [2:0] DEV_LOAD_SECOND = 3'h2;
  localparam logic [2:0] DEV_READ_FIRST  = 3'h3;
  localparam logic [2:0] DEV_READ_SECOND = 3'h4;
  localparam logic [2:0] DEV_CLEAR       = 3'h5;
  localparam logic [2:0] DEV_LOAD_COUNT  = 3'h6;
  localparam logic [2:0] DEV_READ_COUNT  = 3'h7;
  // first control word fields
  localparam int unsigned CW1_TRANSLATE  = 2;
  localparam int unsigned CW1_PACK       = 3;
  localparam int unsigned CW1_REJECT     = 4;
  localparam int unsigned CW1_ERROR      = 5;
  localparam int unsigned CW1_READY      = 6;
  localparam int unsigned CW1_NOT_BUSY   = 7;
  localparam int unsigned CW1_AVAIL      = 8;
  localparam int unsigned CW1_CNT_ZERO   = 9;
  // second control word fields
  localparam int unsigned CW2_TASK_LO    = 0;
  localparam int unsigned CW2_DEC_COUNT  = 6;
  localparam int unsigned CW2_INC_PTR    = 7;
  localparam int unsigned CW2_DEC_PTR    = 8;
  // interrupt status bit positions
  localparam int unsigned IS_READY       = 0;
  localparam int unsigned IS_NOT_BUSY    = 1;
  localparam int unsigned IS_ERROR       = 2;
  localparam int unsigned IS_AVAIL       = 3;
  localparam int unsigned IS_CNT_ZERO    = 4;
  localparam int unsigned IS_REJECT      = 6;
  localparam logic [WORD_W-1:0] WORD_ZERO = 18'h0_0000;
  localparam logic [WORD_W-1:0] ONE_WORD  = 18'h0_0001;
  localparam logic [WORD_W-1:0] TWO_WORD  = 18'h0_0002;
  // propagation delay before status may be read
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned PROP_NS        = 300;
  localparam int unsigned PROP_CYC       = (PROP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0]  PROP_CYC_4     = 4'(PROP_CYC);
endpackage : iocc_pkg

/* File: logic/iocc_devctl.sv */
// device controller: control words, counter, pointer, status register
`timescale 1ns/1ps
module iocc_devctl
  import iocc_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clear_all,
  // device commands
  input  wire logic [2:0]        dev_cmd,
  input  wire logic [WORD_W-1:0] dev_wdata,
  output logic      [WORD_W-1:0] dev_rdata,
  // transfer and device conditions
  input  wire logic              xfer_done,
  input  wire logic              dev_ready,
  input  wire logic              dev_busy,
  input  wire logic              dev_avail,
  input  wire logic              dev_error,
  input  wire logic              dev_reject,
  input  wire logic              status_lock,
  input  wire logic              status_taken,
  // results
  output logic      [WORD_W-1:0] control_word_first,
  output logic      [WORD_W-1:0] control_word_second,
  output logic      [WORD_W-1:0] transfer_counter,
  output logic      [WORD_W-1:0] buffer_pointer,
  output logic      [WORD_W-1:0] int_status,
  output logic                   status_irq_req,
  output logic                   count_zero_stop
);
  logic [WORD_W-1:0] next_cw1, next_cw2, next_cnt, next_ptr, next_is;
  logic              ready_q, busy_q, avail_q;
  logic [WORD_W-1:0] events;
  logic [WORD_W-1:0] step;

  // enabled change events
  always_comb begin
    events = WORD_ZERO;
    step   = control_word_first[CW1_PACK] ? TWO_WORD : ONE_WORD;
    events[IS_READY]    = control_word_first[CW1_READY] & (dev_ready ^ ready_q);
    events[IS_NOT_BUSY] = control_word_first[CW1_NOT_BUSY] & busy_q & ~dev_busy;
    events[IS_AVAIL]    = control_word_first[CW1_AVAIL] & dev_avail & ~avail_q;
    events[IS_ERROR]    = control_word_first[CW1_ERROR] & dev_error;
    events[IS_REJECT]   = control_word_first[CW1_REJECT] & dev_reject;
    events[IS_CNT_ZERO] = control_word_first[CW1_CNT_ZERO] & xfer_done & control_word_second[CW2_DEC_COUNT]
                          & (transfer_counter != WORD_ZERO) & (transfer_counter <= step);
  end

  // next register values
  always_comb begin
    next_cw1 = control_word_first;
    next_cw2 = control_word_second;
    next_cnt = transfer_counter;
    next_ptr = buffer_pointer;
    next_is  = int_status;
    if (clear_all || dev_cmd == DEV_CLEAR) begin
      next_cw1 = WORD_ZERO;
      next_cw2 = WORD_ZERO;
      next_cnt = WORD_ZERO;
      next_ptr = WORD_ZERO;
      next_is  = WORD_ZERO;
    end else begin
      if (dev_cmd == DEV_LOAD_FIRST) next_cw1 = dev_wdata;
      if (dev_cmd == DEV_LOAD_SECOND) next_cw2 = dev_wdata;
      if (dev_cmd == DEV_LOAD_COUNT) begin
        next_cnt = dev_wdata;
        next_is[IS_CNT_ZERO] = 1'b0;
      end else if (xfer_done && control_word_second[CW2_DEC_COUNT]) begin
        next_cnt = (transfer_counter > step) ? transfer_counter - step : WORD_ZERO;
      end
      if (xfer_done && control_word_second[CW2_INC_PTR]) next_ptr = buffer_pointer + ONE_WORD;
      else if (xfer_done && control_word_second[CW2_DEC_PTR]) next_ptr = buffer_pointer - ONE_WORD;
      if (status_taken) next_is = WORD_ZERO;
      if (!status_lock) next_is = next_is | events; // set wins once unlocked
    end
  end

  // register state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_word_first  <= WORD_ZERO;
      control_word_second <= WORD_ZERO;
      transfer_counter    <= WORD_ZERO;
      buffer_pointer      <= WORD_ZERO;
      int_status          <= WORD_ZERO;
      ready_q             <= 1'b0;
      busy_q              <= 1'b0;
      avail_q             <= 1'b0;
    end else begin
      control_word_first  <= next_cw1;
      control_word_second <= next_cw2;
      transfer_counter    <= next_cnt;
      buffer_pointer      <= next_ptr;
      int_status          <= next_is;
      ready_q             <= dev_ready;
      busy_q              <= dev_busy;
      avail_q             <= dev_avail;
    end
  end

  // direct request read mux and status outputs
  always_comb begin
    case (dev_cmd)
      DEV_READ_FIRST:  dev_rdata = control_word_first;
      DEV_READ_SECOND: dev_rdata = control_word_second;
      DEV_READ_COUNT:  dev_rdata = transfer_counter;
      default:         dev_rdata = WORD_ZERO;
    endcase
  end
  assign status_irq_req  = (int_status != WORD_ZERO);
  assign count_zero_stop = int_status[IS_CNT_ZERO];
endmodule : iocc_devctl

/* File: logic/iocc_top.sv */
// channel command interpreter with one device controller
`timescale 1ns/1ps
// Operation
// - code 70 zeroes all registers, flags and status indicators
// - code 71 only in data-out mode; leaves data-out mode at once
// - code 73 enables data interrupt requests to the CPU
// - code 74 and reset block data interrupts until 73
// - code 75 enables status interrupt acceptance; a pending one issues without it
// - code 76 and reset block new status interrupts until 75; only reset or the read strobe ending status mode drops a pending one
// - code 77 after status interrupt enters status mode, locked to device
// - status mode drives interrupt status and device id out
// - read strobe after delay gates status and ends status mode
// - counter decrements, pointer increments or decrements on transfers
// - control words loaded by device commands, readable outside status mode and the data-in and address states
// - first word bit 2 enables character translation
// - first word bit 3 selects packing; counter steps by two
// - first word bits 4,5 mask reject and error interrupts
// - first word bit 6 interrupts on ready change either way
// - first word bit 7 interrupts on busy to not busy
// - first word bit 8 interrupts on unit available
// - first word bit 9 interrupts on counter zero, ends transfer
// - second word bits 0..5 task id driven during data interrupts
// - no new status requests until current one handled
// - data-in needs two read strobes: address then data
// - status bits set before request clear after transfer
// - control words zeroed by reset, I/O reset, clear device
module iocc_top
  import iocc_pkg::*;
#(
  parameter logic [ID_W-1:0] DEVICE_ID = 6'h01 // arbitrary value
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // host command side
  input  wire logic              command_strobe,
  input  wire logic [CMD_W-1:0]  command_bus,
  input  wire logic [PORT_W-1:0] port_select_field,
  input  wire logic              port_read_strobe,
  input  wire logic              port_read_strobe_alt,
  // device command side
  input  wire logic [2:0]        dev_cmd,
  input  wire logic [WORD_W-1:0] dev_wdata,
  // device data and conditions
  input  wire logic              data_in_req,
  input  wire logic              data_out_req,
  input  wire logic [WORD_W-1:0] dev_data,
  input  wire logic [WORD_W-1:0] port_out_data,
  input  wire logic              dev_ready,
  input  wire logic              dev_busy,
  input  wire logic              dev_avail,
  input  wire logic              dev_error,
  input  wire logic              dev_reject,
  // host results
  output logic      [WORD_W-1:0] port_data,
  output logic      [ID_W-1:0]   requester_id_lines,
  output logic                   data_irq,
  output logic                   status_irq,
  output logic                   data_mode,
  output logic                   status_mode,
  output logic                   status_ready,
  // device results
  output logic      [WORD_W-1:0] dev_out_data,
  output logic                   dev_out_strobe,
  output logic                   translate_enable,
  output logic                   byte_packing_select,
  output logic                   xfer_stop
);
  typedef enum logic [2:0] {DM_IDLE, DM_IN_ADDR, DM_IN_DATA, DM_OUT_ADDR, DM_OUT_DATA} iocc_dmode_t;

  iocc_dmode_t       dstate, next_dstate;
  logic              data_en, next_data_en;
  logic              stat_en, next_stat_en;
  logic              stat_pend, next_stat_pend;
  logic              stat_mode, next_stat_mode;
  logic [3:0]        prop_cnt, next_prop_cnt;
  logic [WORD_W-1:0] next_port_data;
  logic [ID_W-1:0]   next_id;
  logic [WORD_W-1:0] next_dev_out;
  logic              next_dev_strobe;
  logic              rd, cmd_valid, io_reset, status_taken, xfer_done;
  logic [WORD_W-1:0] cw1, cw2, cnt, ptr, istat, dev_rdata;
  logic              stat_req_raw, cnt_zero;

  // decode helper for channel codes
  function automatic logic is_cmd(input logic [CMD_W-1:0] code);
    is_cmd = cmd_valid && (command_bus == code);
  endfunction : is_cmd

  assign rd           = port_read_strobe | port_read_strobe_alt;
  assign cmd_valid    = command_strobe;
  assign io_reset     = is_cmd(CMD_IO_RESET);
  assign status_taken = stat_mode && rd && (prop_cnt == 4'h0);
  assign xfer_done    = (dstate == DM_IN_DATA && rd && !stat_mode) || (dstate == DM_OUT_DATA && is_cmd(CMD_DATA_AVAIL));

  // device controller
  iocc_devctl i_iocc_devctl (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .clear_all           (io_reset),
    .dev_cmd             (dev_cmd),
    .dev_wdata           (dev_wdata),
    .dev_rdata           (dev_rdata),
    .xfer_done           (xfer_done),
    .dev_ready           (dev_ready),
    .dev_busy            (dev_busy),
    .dev_avail           (dev_avail),
    .dev_error           (dev_error),
    .dev_reject          (dev_reject),
    .status_lock         (stat_mode),
    .status_taken        (status_taken),
    .control_word_first  (cw1),
    .control_word_second (cw2),
    .transfer_counter    (cnt),
    .buffer_pointer      (ptr),
    .int_status          (istat),
    .status_irq_req      (stat_req_raw),
    .count_zero_stop     (cnt_zero)
  );

  // enables and status sequence next state
  always_comb begin
    next_data_en   = data_en;
    next_stat_en   = stat_en;
    next_stat_pend = stat_pend;
    next_stat_mode = stat_mode;
    next_prop_cnt  = (prop_cnt != 4'h0) ? prop_cnt - 4'h1 : prop_cnt;
    if (io_reset) begin
      next_data_en   = 1'b0;
      next_stat_en   = 1'b0;
      next_stat_pend = 1'b0;
      next_stat_mode = 1'b0;
      next_prop_cnt  = 4'h0;
    end else begin
      if (is_cmd(CMD_EN_DATA)) next_data_en = 1'b1;
      if (is_cmd(CMD_DIS_DATA)) next_data_en = 1'b0;
      if (is_cmd(CMD_EN_STAT)) next_stat_en = 1'b1;
      if (is_cmd(CMD_DIS_STAT)) next_stat_en = 1'b0;
      // code 72 falls through with no effect
      if (!stat_pend && stat_en && stat_req_raw) next_stat_pend = 1'b1;
      if (stat_pend && !stat_mode && is_cmd(CMD_STAT_REQ)) begin
        next_stat_mode = 1'b1;
        next_prop_cnt  = PROP_CYC_4;
      end
      if (status_taken) begin
        next_stat_mode = 1'b0;
        next_stat_pend = 1'b0;
      end
    end
  end

  // data mode sequence next state
  always_comb begin
    next_dstate     = dstate;
    next_dev_out    = dev_out_data;
    next_dev_strobe = 1'b0;
    case (dstate)
      DM_IDLE: begin
        if (data_en && data_in_req && !cnt_zero) next_dstate = DM_IN_ADDR;
        else if (data_en && data_out_req && !cnt_zero) next_dstate = DM_OUT_ADDR;
      end
      DM_IN_ADDR: if (rd && !stat_mode) next_dstate = DM_IN_DATA;
      DM_IN_DATA: if (rd && !stat_mode) next_dstate = DM_IDLE;
      DM_OUT_ADDR: if (rd && !stat_mode) next_dstate = DM_OUT_DATA;
      DM_OUT_DATA: begin
        if (is_cmd(CMD_DATA_AVAIL)) begin
          next_dstate     = DM_IDLE;
          next_dev_out    = port_out_data;
          next_dev_strobe = 1'b1;
        end
      end
      default: next_dstate = DM_IDLE;
    endcase
    if (io_reset) begin
      next_dstate     = DM_IDLE;
      next_dev_out    = WORD_ZERO;
      next_dev_strobe = 1'b0;
    end
  end

  // port data and id lines next values
  always_comb begin
    next_port_data = port_data;
    next_id        = requester_id_lines;
    if (stat_mode) begin
      next_port_data = istat;
      next_id        = DEVICE_ID;
    end else if (dstate == DM_IN_ADDR || dstate == DM_OUT_ADDR) begin
      next_port_data = ptr;
      next_id        = cw2[CW2_TASK_LO +: ID_W];
    end else if (dstate == DM_IN_DATA) begin
      next_port_data = dev_data;
      next_id        = cw2[CW2_TASK_LO +: ID_W];
    end else if (dev_cmd != DEV_NONE) begin
      next_port_data = dev_rdata;
    end
    if (io_reset) begin
      next_port_data = WORD_ZERO;
      next_id        = '0;
    end
  end

  // state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dstate             <= DM_IDLE;
      data_en            <= 1'b0;
      stat_en            <= 1'b0;
      stat_pend          <= 1'b0;
      stat_mode          <= 1'b0;
      prop_cnt           <= 4'h0;
      port_data          <= WORD_ZERO;
      requester_id_lines <= '0;
      dev_out_data       <= WORD_ZERO;
      dev_out_strobe     <= 1'b0;
    end else begin
      dstate             <= next_dstate;
      data_en            <= next_data_en;
      stat_en            <= next_stat_en;
      stat_pend          <= next_stat_pend;
      stat_mode          <= next_stat_mode;
      prop_cnt           <= next_prop_cnt;
      port_data          <= next_port_data;
      requester_id_lines <= next_id;
      dev_out_data       <= next_dev_out;
      dev_out_strobe     <= next_dev_strobe;
    end
  end

  // host and device indications
  assign data_irq            = data_en && (dstate != DM_IDLE);
  assign status_irq          = stat_pend && !stat_mode;
  assign data_mode           = (dstate != DM_IDLE);
  assign status_mode         = stat_mode;
  assign status_ready        = stat_mode && (prop_cnt == 4'h0);
  assign translate_enable    = cw1[CW1_TRANSLATE];
  assign byte_packing_select = cw1[CW1_PACK];
  assign xfer_stop           = cnt_zero;
endmodule : iocc_top

/* File: bench/iocc_host.sv */
// host model: command strobe and read strobe of the selected port
`timescale 1ns/1ps
module iocc_host
  import iocc_pkg::*;
(
  // clock
  input  wire logic             mclk,
  // host strobes
  output logic                  command_strobe,
  output logic      [CMD_W-1:0] command_bus,
  output logic                  port_read_strobe
);
  // idle at time zero
  initial begin
    command_strobe   = 1'h0;
    command_bus      = 6'h00;
    port_read_strobe = 1'h0;
  end
  // one-cycle command pulse with the code held beside it
  task automatic cmd(input logic [CMD_W-1:0] code);
    @(posedge mclk);
    command_strobe <= 1'h1;
    command_bus    <= code;
    @(posedge mclk);
    command_strobe <= 1'h0;
    command_bus    <= ~code; // released lines show no stale code
  endtask : cmd
  // one-cycle read strobe; no propagation wait, caller times it
  task automatic rd();
    @(posedge mclk);
    port_read_strobe <= 1'h1;
    @(posedge mclk);
    port_read_strobe <= 1'h0;
  endtask : rd
endmodule : iocc_host

/* File: bench/iocc_chk_assertions.sv */
// checker: concurrent assertions on the command interpreter ports
`timescale 1ns/1ps
module iocc_chk
  import iocc_pkg::*;
#(
  parameter logic [ID_W-1:0] DEVICE_ID = 6'h01 // arbitrary value
) (
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // host and device inputs
  input wire logic              command_strobe,
  input wire logic [CMD_W-1:0]  command_bus,
  input wire logic              port_read_strobe,
  input wire logic [2:0]        dev_cmd,
  input wire logic [WORD_W-1:0] dev_wdata,
  input wire logic [WORD_W-1:0] port_out_data,
  // results
  input wire logic [ID_W-1:0]   requester_id_lines,
  input wire logic              data_irq,
  input wire logic              status_irq,
  input wire logic              data_mode,
  input wire logic              status_mode,
  input wire logic              status_ready,
  input wire logic [WORD_W-1:0] dev_out_data,
  input wire logic              dev_out_strobe,
  input wire logic              translate_enable,
  input wire logic              byte_packing_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // decoded command strobes
  wire c70 = command_strobe && command_bus == CMD_IO_RESET;
  wire c71 = command_strobe && command_bus == CMD_DATA_AVAIL;
  wire c72 = command_strobe && command_bus == CMD_UNASSIGNED;
  wire c74 = command_strobe && command_bus == CMD_DIS_DATA;
  wire c76 = command_strobe && command_bus == CMD_DIS_STAT;
  wire c77 = command_strobe && command_bus == CMD_STAT_REQ;
  // status request steps
  sequence s_stat_req;
    c77 && status_irq && !status_mode;
  endsequence
  sequence s_stat_answer;
    status_mode ##1 requester_id_lines == DEVICE_ID ##[0:6] status_ready;
  endsequence
  property p_reset;
    c70 |-> ##[1:2] !(data_irq || status_irq || data_mode || status_mode || translate_enable || byte_packing_select);
  endproperty
  property p_load;
    dev_cmd == DEV_LOAD_FIRST && !command_strobe
      |=> {byte_packing_select, translate_enable} == $past(dev_wdata[CW1_PACK:CW1_TRANSLATE]);
  endproperty
  property p_nop;
    c72 && dev_cmd == DEV_NONE |=> $stable({translate_enable, byte_packing_select});
  endproperty
  property p_stat;
    s_stat_req |=> s_stat_answer;
  endproperty
  property p_early;
    status_mode && !status_ready && port_read_strobe |=> status_mode;
  endproperty
  property p_release;
    status_mode && status_ready && port_read_strobe |=> !status_mode;
  endproperty
  property p_lock;
    (!status_mode && !command_strobe) [*4] ##0 status_irq |=> status_irq;
  endproperty
  property p_dis_stat;
    c76 ##1 !status_irq |=> !status_irq [*4];
  endproperty
  property p_dis_data;
    c74 ##1 !data_irq |=> !data_irq [*4];
  endproperty
  property p_out;
    dev_out_strobe |-> $past(c71) && dev_out_data == $past(port_out_data);
  endproperty
  a_reset: assert property (p_reset) else $error("io reset left state set");
  a_load: assert property (p_load) else $error("first word bits not applied");
  a_nop: assert property (p_nop) else $error("unassigned code changed state");
  a_stat: assert property (p_stat) else $error("status mode entry wrong");
  a_early: assert property (p_early) else $error("early strobe left status mode");
  a_release: assert property (p_release) else $error("strobe did not end status mode");
  a_lock: assert property (p_lock) else $error("pending status interrupt lost");
  a_dis_stat: assert property (p_dis_stat) else $error("status interrupt while disabled");
  a_dis_data: assert property (p_dis_data) else $error("data interrupt while disabled");
  a_out: assert property (p_out) else $error("output word not from data available");
endmodule : iocc_chk

bind iocc_top iocc_chk #(.DEVICE_ID(DEVICE_ID)) i_iocc_chk (.mclk, .rst_n, .command_strobe, .command_bus,
  .port_read_strobe, .dev_cmd, .dev_wdata, .port_out_data, .requester_id_lines, .data_irq, .status_irq,
  .data_mode, .status_mode, .status_ready, .dev_out_data, .dev_out_strobe, .translate_enable, .byte_packing_select);

/* File: bench/test_io_channel_command_control.sv */
// self-checking bench for the channel command interpreter
`timescale 1ns/1ps
module test_io_channel_command_control import iocc_pkg::*;;
  localparam logic [ID_W-1:0] DEV_ID = 6'h2A; // arbitrary value
  logic              mclk, rst_n, data_in_req, data_out_req, dev_ready, dev_busy;
  logic [2:0]        dev_cmd;
  logic [WORD_W-1:0] dev_wdata, dev_data, port_out_data, seed;
  logic [ID_W-1:0]   tid;
  wire               command_strobe, port_read_strobe, data_irq, status_irq, data_mode, status_mode;
  wire               status_ready, dev_out_strobe, translate_enable, byte_packing_select, xfer_stop;
  wire [CMD_W-1:0]   command_bus;
  wire [WORD_W-1:0]  port_data, dev_out_data;
  wire [ID_W-1:0]    requester_id_lines;
  int                fails, checks_done, cycles, i, k;
  iocc_host i_iocc_host (.mclk, .command_strobe, .command_bus, .port_read_strobe);
  iocc_top #(.DEVICE_ID(DEV_ID)) i_iocc_top (.mclk, .rst_n, .command_strobe, .command_bus,
    .port_select_field(4'h0), .port_read_strobe, .port_read_strobe_alt(1'h0), .dev_cmd, .dev_wdata,
    .data_in_req, .data_out_req, .dev_data, .port_out_data, .dev_ready, .dev_busy, .dev_avail(1'h0),
    .dev_error(1'h0), .dev_reject(1'h0), .port_data, .requester_id_lines, .data_irq, .status_irq, .data_mode,
    .status_mode, .status_ready, .dev_out_data, .dev_out_strobe, .translate_enable, .byte_packing_select, .xfer_stop);
  // clock and hang limit
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end
  function automatic logic [WORD_W-1:0] lf(input logic [WORD_W-1:0] s);
    return {s[16:0], s[17] ^ s[10]};
  endfunction : lf
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(input string n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic devc(input logic [2:0] c, input logic [WORD_W-1:0] d);
    @(posedge mclk);
    dev_cmd   <= c;
    dev_wdata <= d;
    @(posedge mclk);
    dev_cmd   <= DEV_NONE;
    dev_wdata <= ~d;
  endtask : devc
  // one status interrupt handled end to end
  task automatic stat_round(input logic [WORD_W-1:0] e);
    for (i = 0; i < 12 && status_irq !== 1'h1; i++) cyc(1);
    chk("status_irq", 1, status_irq);
    i_iocc_host.cmd(CMD_UNASSIGNED);
    cyc(2);
    chk("after nop", 1, status_irq);
    i_iocc_host.cmd(CMD_STAT_REQ);
    cyc(1);
    chk("status_mode", 1, status_mode);
    i_iocc_host.rd();
    cyc(1);
    chk("early strobe", 1, status_mode);
    for (i = 0; i < 9 && status_ready !== 1'h1; i++) cyc(1);
    chk("int status", e, port_data);
    chk("device id", DEV_ID, requester_id_lines);
    i_iocc_host.rd();
    cyc(2);
    chk("released", 0, status_mode);
  endtask : stat_round
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // main sequence
  initial begin
    rst_n = 1'h0;
    data_in_req = 1'h0;
    data_out_req = 1'h0;
    dev_ready = 1'h0;
    dev_busy = 1'h1;
    dev_cmd = DEV_NONE;
    dev_wdata = WORD_ZERO;
    dev_data = WORD_ZERO;
    port_out_data = WORD_ZERO;
    seed = 18'h0_0005;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    cyc(1);
    chk("reset state", 0, {data_irq, status_irq, data_mode, status_mode});
    for (k = 0; k < 4; k++) begin
      seed = lf(seed);
      devc(DEV_LOAD_FIRST, seed);
      cyc(1);
      chk("map bits", seed[3:2], {byte_packing_select, translate_enable});
    end
    devc(DEV_CLEAR, WORD_ZERO);
    cyc(1);
    chk("cleared word", 0, {byte_packing_select, translate_enable});
    devc(DEV_LOAD_FIRST, 18'h0_00C0);
    i_iocc_host.cmd(CMD_EN_STAT);
    @(posedge mclk) dev_ready <= 1'h1;
    stat_round(ONE_WORD << IS_READY);
    @(posedge mclk) dev_busy <= 1'h0;
    stat_round(ONE_WORD << IS_NOT_BUSY);
    i_iocc_host.cmd(CMD_DIS_STAT);
    @(posedge mclk) dev_ready <= 1'h0;
    cyc(10);
    chk("status blocked", 0, status_irq);
    seed = lf(seed);
    tid = seed[5:0];
    devc(DEV_LOAD_SECOND, 18'h0_00C0 | tid);
    devc(DEV_LOAD_FIRST, 18'h0_0204);
    devc(DEV_LOAD_COUNT, TWO_WORD);
    i_iocc_host.cmd(CMD_EN_STAT);
    i_iocc_host.cmd(CMD_EN_DATA);
    for (k = 0; k < 2; k++) begin
      seed = lf(seed);
      @(posedge mclk) data_in_req <= 1'h1;
      dev_data <= seed;
      for (i = 0; i < 12 && data_mode !== 1'h1; i++) cyc(1);
      cyc(1); // address and task id follow data mode by one cycle
      chk("task id", tid, requester_id_lines);
      chk("address", 18'(k), port_data);
      @(posedge mclk) data_in_req <= 1'h0;
      i_iocc_host.rd();
      cyc(8);
      chk("data mode held", 1, data_mode);
      chk("data word", seed, port_data);
      i_iocc_host.rd();
      cyc(2);
      chk("data mode left", 0, data_mode);
    end
    chk("count stop", 1, xfer_stop);
    devc(DEV_LOAD_COUNT, 18'h0_0005);
    cyc(1);
    chk("stop cleared", 0, xfer_stop);
    @(posedge mclk) data_out_req <= 1'h1;
    for (i = 0; i < 12 && data_mode !== 1'h1; i++) cyc(1);
    @(posedge mclk) data_out_req <= 1'h0;
    i_iocc_host.rd();
    seed = lf(seed);
    @(posedge mclk) port_out_data <= seed;
    i_iocc_host.cmd(CMD_DATA_AVAIL);
    cyc(1);
    chk("out word", seed, dev_out_data);
    chk("out mode left", 0, data_mode);
    i_iocc_host.cmd(CMD_DIS_DATA);
    @(posedge mclk) data_in_req <= 1'h1;
    cyc(10);
    chk("data blocked", 0, data_mode);
    i_iocc_host.cmd(CMD_IO_RESET);
    cyc(10);
    chk("io reset", 0, {status_irq, data_mode, translate_enable, xfer_stop});
    results();
  end
endmodule : test_io_channel_command_control
